// ===== rtl/nest_irq_ctrl.sv
// Nested interrupt controller: latching, levels, arbitration and wake-up
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - Service only enabled requests above current level
// - Edge external requests latched, cleared on entry
// - Pins of one group ORed together
// - Peripheral request is flag AND enable
// - Flag clear sequence drops pending latch
// - Any source wakes WAIT; HALT-capable wake HALT
// - First after HALT only HALT-capable
// - Blocked higher request follows right after
// - Lower vector number wins equal levels
// - Level codes 10,01,00,11; 11 blocks all maskable
// - Entry loads level from vector priority
// - Enable loads 10, disable loads 11
// - Trap and reset preempt, set level 3
// - Reset ranks highest, starts at level 3
// - Priority regs reset FF, last upper ones
// - Pair 0 at top vector, downward numbering
// - Level 0 code write keeps old pair
// - Raised priority of pending vector re-enters
// - Instructions change level until next return
// - Vector addresses per source table
// - External and serial sync wake HALT only
// - Active-Halt wake depends on part kind
// - Highest software then hardware priority
module nest_irq_ctrl #(
  parameter logic ROM_PART = 1'b0   // One for mask-ROM parts
) (
  input  wire logic                      clk_sys,     // System clock
  input  wire logic                      rstn,        // Async reset, low
  input  wire logic                      clk_en,      // Freezes all state
  input  wire logic [3:0]                reg_addr,    // Register index
  input  wire logic [7:0]                reg_wdata,   // Write data
  input  wire logic                      reg_wr,      // Write strobe
  input  wire logic                      reg_rd,      // Read strobe
  output logic [7:0]                     reg_rdata,   // Read data, next cycle
  input  wire logic [3:0]                pins_a,      // Port A line pins
  input  wire logic [2:0]                pins_f,      // Port F line pins
  input  wire logic [3:0]                pins_bl,     // Port B low pins
  input  wire logic [3:0]                pins_bh,     // Port B high pins
  input  wire logic [13:0]               ext_edge,    // Edge event per line
  input  wire logic [13:0]               periph_flag, // Peripheral flags
  input  wire logic [13:0]               periph_en,   // Peripheral enables
  input  wire logic [13:0]               flag_clear,  // Clear sequence seen
  input  wire nest_irq_pkg::cpu_req_type cpu_req,     // CPU boundary events
  output nest_irq_pkg::arb_type          arb_out,     // Winner to the CPU
  output logic [1:0]                     level_out,   // Current level bits
  output logic                           wake_out     // Wake from low power
);
  logic [7:0]  prio_reg [nest_irq_pkg::NUM_PRIO_REGS];
  logic [13:0] edge_reg;
  logic [13:0] edge_next;
  logic [7:0]  cc_reg;
  logic [1:0]  pwr_reg;
  logic        halt_first_reg;
  logic [13:0] req;
  logic [13:0] line_level;
  nest_irq_pkg::arb_type arb_next;
  logic        wake_next;
  logic [7:0]  rdata_next;
  logic [1:0]  take_pair;

  // Rank of a level code; code 11 ranks 3, the highest
  function automatic logic [2:0] rank(input logic [1:0] code);
    case (code)
      nest_irq_pkg::LVL0_CODE: rank = 3'h0;
      nest_irq_pkg::LVL1_CODE: rank = 3'h1;
      nest_irq_pkg::LVL2_CODE: rank = 3'h2;
      default:                 rank = 3'h3;
    endcase
  endfunction

  function automatic logic [1:0] pair(input int v);
    pair = prio_reg[v / 4][(v % 4) * 2 +: 2];
  endfunction

  // Stored priority of the vector being entered
  assign take_pair = pair(int'(arb_out.vec));

  function automatic logic [15:0] vaddr(input logic [3:0] v);
    vaddr = nest_irq_pkg::ADDR_VEC0 -
            16'(v) * nest_irq_pkg::ADDR_STEP;
  endfunction

  // Level-sensitive pins ORed per group; active low pins request
  always_comb begin
    line_level = '0;
    line_level[nest_irq_pkg::VEC_EXT_A]  = |(~pins_a);
    line_level[nest_irq_pkg::VEC_EXT_F]  = |(~pins_f);
    line_level[nest_irq_pkg::VEC_EXT_BL] = |(~pins_bl);
    line_level[nest_irq_pkg::VEC_EXT_BH] = |(~pins_bh);
  end

  // Edge latches: set wins over clear so a late edge is never lost
  always_comb begin
    edge_next = edge_reg;
    if (arb_out.valid && !arb_out.nonmask && cpu_req.take)
      edge_next[arb_out.vec] = 1'b0;
    edge_next = edge_next & ~flag_clear;
    edge_next = edge_next | (ext_edge & nest_irq_pkg::EDGE_MASK);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      edge_reg <= '0;
    end else if (clk_en) begin
      edge_reg <= edge_next;
    end
  end

  // Peripheral request is a plain AND; clearing the flag drops it
  assign req = edge_reg | line_level |
               (periph_flag & periph_en & ~flag_clear);

  // Priority registers with level-0 write protection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < nest_irq_pkg::NUM_PRIO_REGS; i++)
        prio_reg[i] <= nest_irq_pkg::PRIO_RESET;
    end else if (clk_en && reg_wr && reg_addr <= nest_irq_pkg::OFF_PRIO3) begin
      for (int p = 0; p < 4; p++) begin
        if (reg_wdata[p*2 +: 2] != nest_irq_pkg::LVL0_CODE)
          prio_reg[reg_addr[1:0]][p*2 +: 2] <= reg_wdata[p*2 +: 2];
      end
      if (reg_addr == nest_irq_pkg::OFF_PRIO3)
        prio_reg[3][7:4] <= nest_irq_pkg::PRIO3_RO_MASK[7:4];
    end
  end

  // Arbitration from edge latches, live pin levels and peripheral requests, with live priorities
  always_comb begin
    logic [2:0] best;
    logic [2:0] cur;
    logic [13:0] cand;
    best = '0;
    cur = rank(cc_reg[nest_irq_pkg::CC_BIT_HIGH -: 1] == 1'b1 ?
               {1'b1, cc_reg[nest_irq_pkg::CC_BIT_LOW]} :
               {1'b0, cc_reg[nest_irq_pkg::CC_BIT_LOW]});
    arb_next = '0;
    cand = req;
    // Restrict while still halted, so the winner taken on exit is capable
    if (pwr_reg == nest_irq_pkg::PWR_HALT ||
        pwr_reg == nest_irq_pkg::PWR_AHALT)
      cand = req & nest_irq_pkg::HALT_WAKE;
    // Walk upward from lowest hardware priority so the lowest vector
    // number wins any tie
    for (int v = nest_irq_pkg::NUM_VEC - 1; v >= 0; v--) begin
      if (cand[v] && rank(pair(v)) > cur &&
          rank(pair(v)) >= best && rank(pair(v)) != 3'h0) begin
        best = rank(pair(v));
        arb_next.valid = 1'b1;
        arb_next.vec = 4'(v);
        arb_next.addr = vaddr(4'(v));
      end
    end
    if (cpu_req.take_trap) begin
      arb_next.valid = 1'b1;
      arb_next.nonmask = 1'b1;
      arb_next.vec = '0;
      arb_next.addr = nest_irq_pkg::ADDR_TRAP;
    end
    if (cpu_req.take_reset) begin
      arb_next.valid = 1'b1;
      arb_next.nonmask = 1'b1;
      arb_next.vec = '0;
      arb_next.addr = nest_irq_pkg::ADDR_RESET;
    end
    arb_next.wake = wake_next;
  end

  // Wake-up decision by power state
  always_comb begin
    logic [13:0] ah;
    ah = ROM_PART ? nest_irq_pkg::AHALT_ROM : nest_irq_pkg::AHALT_FLASH;
    case (nest_irq_pkg::pwr_type'(pwr_reg))
      nest_irq_pkg::PWR_WAIT:  wake_next = |req;
      nest_irq_pkg::PWR_HALT:
        wake_next = |(req & nest_irq_pkg::HALT_WAKE);
      nest_irq_pkg::PWR_AHALT: wake_next = |(req & ah);
      default:                 wake_next = 1'b0;
    endcase
    if (cpu_req.take_reset)
      wake_next = 1'b1;
  end

  // Power state and the HALT-exit restriction
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwr_reg <= nest_irq_pkg::PWR_RUN;
      halt_first_reg <= 1'b0;
    end else if (clk_en) begin
      if (cpu_req.take || cpu_req.take_reset) begin
        if (pwr_reg != nest_irq_pkg::PWR_RUN)
          halt_first_reg <= (pwr_reg != nest_irq_pkg::PWR_WAIT) &&
                            !cpu_req.take_reset;
        else
          halt_first_reg <= 1'b0;
        pwr_reg <= nest_irq_pkg::PWR_RUN;
      end else if (cpu_req.instr == nest_irq_pkg::INSTR_WAIT) begin
        pwr_reg <= nest_irq_pkg::PWR_WAIT;
      end else if (cpu_req.instr == nest_irq_pkg::INSTR_HALT) begin
        pwr_reg <= cpu_req.ahalt ? nest_irq_pkg::PWR_AHALT :
                                   nest_irq_pkg::PWR_HALT;
      end
    end
  end

  // Condition-code level bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cc_reg <= nest_irq_pkg::CC_RESET;
      cc_reg[nest_irq_pkg::CC_BIT_HIGH] <= 1'b1;
      cc_reg[nest_irq_pkg::CC_BIT_LOW] <= 1'b1;
    end else if (clk_en) begin
      if (cpu_req.take_reset || cpu_req.take_trap ||
          (cpu_req.take && arb_out.nonmask)) begin
        cc_reg[nest_irq_pkg::CC_BIT_HIGH] <= 1'b1;
        cc_reg[nest_irq_pkg::CC_BIT_LOW] <= 1'b1;
      end else if (cpu_req.take && arb_out.valid) begin
        cc_reg[nest_irq_pkg::CC_BIT_HIGH] <= take_pair[1];
        cc_reg[nest_irq_pkg::CC_BIT_LOW] <= take_pair[0];
      end else begin
        case (cpu_req.instr)
          nest_irq_pkg::INSTR_ENABLE_ALL, nest_irq_pkg::INSTR_WAIT,
          nest_irq_pkg::INSTR_HALT: begin
            cc_reg[nest_irq_pkg::CC_BIT_HIGH] <= 1'b1;
            cc_reg[nest_irq_pkg::CC_BIT_LOW] <= 1'b0;
          end
          nest_irq_pkg::INSTR_DISABLE_ALL: begin
            cc_reg[nest_irq_pkg::CC_BIT_HIGH] <= 1'b1;
            cc_reg[nest_irq_pkg::CC_BIT_LOW] <= 1'b1;
          end
          nest_irq_pkg::INSTR_RETURN, nest_irq_pkg::INSTR_POP_CC: begin
            cc_reg <= cpu_req.pop_value;
          end
          default: begin
          end
        endcase
        if (reg_wr && reg_addr == nest_irq_pkg::OFF_CC)
          cc_reg <= reg_wdata;
      end
    end
  end

  // Register read decode
  always_comb begin
    if (reg_addr <= nest_irq_pkg::OFF_PRIO3)
      rdata_next = prio_reg[reg_addr[1:0]];
    else if (reg_addr == nest_irq_pkg::OFF_CC)
      rdata_next = cc_reg;
    else if (reg_addr == nest_irq_pkg::OFF_PEND)
      rdata_next = req[7:0];
    else if (reg_addr == nest_irq_pkg::OFF_PEND_HI)
      rdata_next = {2'h0, req[13:8]};
    else if (reg_addr == nest_irq_pkg::OFF_MODE)
      rdata_next = {5'h0, halt_first_reg, pwr_reg};
    else
      rdata_next = 8'h00;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  // Registered outputs; CPU samples them at instruction boundaries
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arb_out <= '0;
      level_out <= nest_irq_pkg::LVL3_CODE;
      wake_out <= 1'b0;
    end else if (clk_en) begin
      arb_out <= arb_next;
      level_out <= {cc_reg[nest_irq_pkg::CC_BIT_HIGH],
                    cc_reg[nest_irq_pkg::CC_BIT_LOW]};
      wake_out <= wake_next;
    end
  end

  a_level3_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
    (level_out == nest_irq_pkg::LVL3_CODE && !arb_out.nonmask &&
     $stable(cc_reg)) |-> ##1 !(arb_out.valid && !arb_out.nonmask))
    else $error("maskable win at level 3");
  a_prio3_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
    prio_reg[3][7:4] == 4'hf)
    else $error("priority 3 upper bits not ones");
  a_reset_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && cpu_req.take_reset |=> cc_reg[5] && cc_reg[3])
    else $error("reset did not set level 3");
  a_enable_all: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && !cpu_req.take && !cpu_req.take_reset && !reg_wr &&
    cpu_req.instr == nest_irq_pkg::INSTR_ENABLE_ALL
    |=> cc_reg[5] && !cc_reg[3])
    else $error("enable-all did not load 10");
  a_level0_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h2
    |=> prio_reg[0][1:0] == $past(prio_reg[0][1:0]))
    else $error("level 0 code was stored");
  a_edge_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && ext_edge[2] |=> edge_reg[2])
    else $error("edge event lost");
  a_halt_first: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pwr_reg == nest_irq_pkg::PWR_HALT || pwr_reg == nest_irq_pkg::PWR_AHALT)
    && clk_en |=> !arb_out.valid || arb_out.nonmask ||
    (nest_irq_pkg::HALT_WAKE[arb_out.vec]))
    else $error("non HALT source served first");
  a_periph_req: assert property (@(posedge clk_sys) disable iff (!rstn)
    periph_flag[8] && !periph_en[8] && !edge_reg[8] |-> !req[8])
    else $error("request without enable");
  c_reset_take: cover property (@(posedge clk_sys) cpu_req.take_reset);
  c_nested: cover property (@(posedge clk_sys)
    arb_out.valid && level_out != nest_irq_pkg::LVL0_CODE);
  c_halt_wake: cover property (@(posedge clk_sys) wake_out && halt_first_reg);
endmodule // nest_irq_ctrl

// ===== rtl/nest_irq_pkg.sv
// Constants, types and register layout of the nested interrupt controller
package nest_irq_pkg;
  localparam int          NUM_VEC        = 14;
  localparam int          NUM_PRIO_REGS  = 4;
  localparam int          VEC_W          = 4;
  localparam logic [7:0]  PRIO_RESET     = 8'hff;
  localparam logic [7:0]  PRIO3_RO_MASK  = 8'hf0;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0]  OFF_PRIO0      = 4'h0;
  localparam logic [3:0]  OFF_PRIO1      = 4'h1;
  localparam logic [3:0]  OFF_PRIO2      = 4'h2;
  localparam logic [3:0]  OFF_PRIO3      = 4'h3;
  localparam logic [3:0]  OFF_CC         = 4'h4;
  localparam logic [3:0]  OFF_PEND       = 4'h5;
  localparam logic [3:0]  OFF_PEND_HI    = 4'h6;
  localparam logic [3:0]  OFF_MODE       = 4'h7;
  // Level bits position in the condition code byte
  localparam int          CC_BIT_HIGH    = 5;
  localparam int          CC_BIT_LOW     = 3;
  localparam logic [7:0]  CC_RESET       = 8'hea;
  // Level codes (high bit, low bit)
  localparam logic [1:0]  LVL0_CODE      = 2'h2;
  localparam logic [1:0]  LVL1_CODE      = 2'h1;
  localparam logic [1:0]  LVL2_CODE      = 2'h0;
  localparam logic [1:0]  LVL3_CODE      = 2'h3;
  // Vector numbers of the sources
  localparam logic [3:0]  VEC_TIMEBASE   = 4'h1;
  localparam logic [3:0]  VEC_EXT_A      = 4'h2;
  localparam logic [3:0]  VEC_EXT_F      = 4'h3;
  localparam logic [3:0]  VEC_EXT_BL     = 4'h4;
  localparam logic [3:0]  VEC_EXT_BH     = 4'h5;
  localparam logic [3:0]  VEC_SPI        = 4'h7;
  localparam logic [3:0]  VEC_TIMER_A    = 4'h8;
  localparam logic [3:0]  VEC_TIMER_B    = 4'h9;
  localparam logic [3:0]  VEC_SERIAL     = 4'ha;
  // Vector addresses, low byte of the pair
  localparam logic [15:0] ADDR_RESET     = 16'hfffe;
  localparam logic [15:0] ADDR_TRAP      = 16'hfffc;
  localparam logic [15:0] ADDR_VEC0      = 16'hfffa;
  localparam logic [15:0] ADDR_STEP      = 16'h0002;
  // Sources that may leave HALT, and Active-Halt on each part kind
  localparam logic [13:0] HALT_WAKE      = 14'h00bc;
  localparam logic [13:0] AHALT_FLASH    = 14'h0002;
  localparam logic [13:0] AHALT_ROM      = 14'h00be;
  localparam logic [13:0] EDGE_MASK      = 14'h003c;

  typedef enum logic [2:0] {
    INSTR_NONE, INSTR_ENABLE_ALL, INSTR_DISABLE_ALL, INSTR_WAIT,
    INSTR_HALT, INSTR_RETURN, INSTR_POP_CC
  } instr_type;

  typedef enum logic [1:0] {
    PWR_RUN, PWR_WAIT, PWR_HALT, PWR_AHALT
  } pwr_type;

  typedef struct packed {
    logic        take;
    logic        take_trap;
    logic        take_reset;
    instr_type   instr;
    logic [7:0]  pop_value;
    logic        ahalt;
  } cpu_req_type;

  typedef struct packed {
    logic        valid;
    logic        nonmask;
    logic [3:0]  vec;
    logic [15:0] addr;
    logic        wake;
  } arb_type;
endpackage

// ===== tb/cpu_model.sv
// CPU core model: issues instruction-boundary events to the controller
`timescale 1ns/1ns
module cpu_model (
  input  wire logic                 clk_sys, // System clock
  input  wire nest_irq_pkg::arb_type arb,    // Current winner
  output nest_irq_pkg::cpu_req_type req      // Boundary events
);
  initial req = '0;

  // Each event lasts one cycle, as the core only acts on boundaries
  task automatic exec(input nest_irq_pkg::instr_type i,
                      input logic [7:0] pv);
    @(posedge clk_sys);
    req.instr     <= i;
    req.pop_value <= pv;
    @(posedge clk_sys);
    req.instr     <= nest_irq_pkg::INSTR_NONE;
  endtask

  task automatic take_irq();
    @(posedge clk_sys);
    req.take <= 1'b1;
    @(posedge clk_sys);
    req.take <= 1'b0;
  endtask

  task automatic trap();
    @(posedge clk_sys);
    req.take_trap <= 1'b1;
    @(posedge clk_sys);
    req.take_trap <= 1'b0;
  endtask
endmodule // cpu_model

// ===== tb/tb_top.sv
// Self-checking testbench of the nested interrupt controller
`timescale 1ns/1ns
module tb_top;
  logic                      clk_sys, rstn, reg_wr, reg_rd, wake_out;
  logic [3:0]                reg_addr;
  logic [7:0]                reg_wdata, reg_rdata;
  logic [13:0]               ext_edge, periph_flag, periph_en, flag_clear;
  logic [1:0]                level_out;
  logic [2:0]                pins_f;
  nest_irq_pkg::cpu_req_type cpu_req;
  nest_irq_pkg::arb_type     arb_out;
  int                        num_errors = 0;
  int                        cmp_count = 0;
  int                        cyc = 0;

  nest_irq_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_a(4'hf),
    .pins_f(pins_f), .pins_bl(4'hf), .pins_bh(4'hf), .ext_edge(ext_edge),
    .periph_flag(periph_flag), .periph_en(periph_en),
    .flag_clear(flag_clear), .cpu_req(cpu_req), .arb_out(arb_out),
    .level_out(level_out), .wake_out(wake_out));

  cpu_model cpu (.clk_sys(clk_sys), .arb(arb_out), .req(cpu_req));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs under two hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(i[3:0], d);
      chk(d, 8'hff, "prio reset");
    end
    rd(nest_irq_pkg::OFF_CC, d);
    chk(d, nest_irq_pkg::CC_RESET, "cc reset");
    rd(4'h8, d);
    chk(d, 8'h00, "unmapped read");
    wr(nest_irq_pkg::OFF_PRIO3, 8'h00);
    rd(nest_irq_pkg::OFF_PRIO3, d);
    chk(d, 8'hf0, "prio3 upper bits");
    wr(nest_irq_pkg::OFF_PRIO0, 8'hcf);
    wr(nest_irq_pkg::OFF_PRIO0, 8'h64);
    rd(nest_irq_pkg::OFF_PRIO0, d);
    chk(d, 8'h44, "level0 pair kept");
    $display("test regs done");
  endtask

  task automatic t_arb();
    cpu.exec(nest_irq_pkg::INSTR_ENABLE_ALL, 8'h00);
    tick(3);
    chk(level_out, nest_irq_pkg::LVL0_CODE, "enable all");
    wr(nest_irq_pkg::OFF_PRIO2, 8'hf1);
    @(posedge clk_sys) periph_flag <= 14'h0300;
    tick(3);
    chk(arb_out.valid, 1'b0, "flag without enable");
    @(posedge clk_sys) periph_en <= 14'h0300;
    tick(3);
    chk(arb_out.vec, nest_irq_pkg::VEC_TIMER_B, "sw prio wins");
    chk(arb_out.addr, 16'hffe8, "timer b vector");
    wr(nest_irq_pkg::OFF_PRIO2, 8'hf0);
    tick(3);
    chk(arb_out.vec, nest_irq_pkg::VEC_TIMER_A, "hw tie break");
    chk(arb_out.addr, 16'hffea, "timer a vector");
    cpu.exec(nest_irq_pkg::INSTR_DISABLE_ALL, 8'h00);
    tick(3);
    chk(level_out, nest_irq_pkg::LVL3_CODE, "disable all");
    chk(arb_out.valid, 1'b0, "level 3 blocks");
    cpu.exec(nest_irq_pkg::INSTR_ENABLE_ALL, 8'h00);
    tick(3);
    $display("test arbitration done");
  endtask

  task automatic t_nest();
    cpu.take_irq();
    tick(3);
    chk(level_out, nest_irq_pkg::LVL2_CODE, "entry level");
    chk(arb_out.valid, 1'b0, "equal level waits");
    wr(nest_irq_pkg::OFF_PRIO2, 8'hf3);
    tick(3);
    chk(arb_out.valid, 1'b1, "raised prio re-enters");
    chk(arb_out.vec, nest_irq_pkg::VEC_TIMER_A, "re-entered vector");
    @(posedge clk_sys) periph_flag <= '0;
    cpu.trap();
    tick(3);
    chk(level_out, nest_irq_pkg::LVL3_CODE, "trap level");
    cpu.exec(nest_irq_pkg::INSTR_RETURN, 8'he2);
    tick(3);
    chk(level_out, nest_irq_pkg::LVL0_CODE, "return level");
    $display("test nesting done");
  endtask

  task automatic pulse_edge();
    @(posedge clk_sys) ext_edge[2] <= 1'b1;
    @(posedge clk_sys) ext_edge <= '0;
  endtask

  task automatic t_edge();
    wr(nest_irq_pkg::OFF_PRIO0, 8'hdf);
    pulse_edge();
    tick(3);
    chk(arb_out.vec, nest_irq_pkg::VEC_EXT_A, "edge latched");
    chk(arb_out.addr, 16'hfff6, "ext line vector");
    @(posedge clk_sys) flag_clear[2] <= 1'b1;
    @(posedge clk_sys) flag_clear <= '0;
    tick(3);
    chk(arb_out.valid, 1'b0, "clear drops pending");
    pulse_edge();
    tick(3);
    cpu.take_irq();
    tick(3);
    chk(level_out, nest_irq_pkg::LVL1_CODE, "edge entry level");
    cpu.exec(nest_irq_pkg::INSTR_RETURN, 8'he2);
    tick(3);
    chk(arb_out.valid, 1'b0, "cleared on entry");
    $display("test edge done");
  endtask

  task automatic t_pins();
    @(posedge clk_sys) pins_f <= 3'h5;
    tick(3);
    chk(arb_out.vec, nest_irq_pkg::VEC_EXT_F, "pin group ORed");
    chk(arb_out.addr, 16'hfff4, "ext f vector");
    @(posedge clk_sys) pins_f <= 3'h7;
    tick(3);
    chk(arb_out.valid, 1'b0, "pins released");
    $display("test pins done");
  endtask

  task automatic t_halt();
    cpu.exec(nest_irq_pkg::INSTR_HALT, 8'h00);
    @(posedge clk_sys) periph_flag <= 14'h0100;
    tick(3);
    chk(wake_out, 1'b0, "timer no halt wake");
    chk(arb_out.valid, 1'b0, "halt restricts");
    pulse_edge();
    tick(3);
    chk(wake_out, 1'b1, "ext wakes halt");
    chk(arb_out.vec, nest_irq_pkg::VEC_EXT_A, "halt capable first");
    cpu.take_irq();
    tick(3);
    chk(arb_out.vec, nest_irq_pkg::VEC_TIMER_A, "blocked one next");
    @(posedge clk_sys) periph_flag <= '0;
    cpu.exec(nest_irq_pkg::INSTR_RETURN, 8'he2);
    cpu.exec(nest_irq_pkg::INSTR_WAIT, 8'h00);
    @(posedge clk_sys) periph_flag <= 14'h0100;
    tick(3);
    chk(wake_out, 1'b1, "any source wakes wait");
    @(posedge clk_sys) periph_flag <= '0;
    $display("test low power done");
  endtask

  initial begin
    rstn        = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    ext_edge    = '0;
    periph_flag = '0;
    periph_en   = '0;
    flag_clear  = '0;
    pins_f      = 3'h7;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_arb();
    t_nest();
    t_edge();
    t_pins();
    t_halt();
    end_of_test();
  end
endmodule // tb_top
